// ---- core/ebcs_sequencer.sv ----
// Bus cycle sequencer for the latch-enable and strobe bus modes
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Latch mode: T1 to T4 plus waits
// - Each state lasts 2 to 15 clocks
// - Latch strobe high at T1 start, low mid-T1
// - T3 holds outputs; early low ready adds waits
// - Separate read: capture at T4 start, end
// - Separate write: address, select, data in T1
// - Write strobe plus memory or io in T2
// - Write strobe drops at T4; buses held through T4
// - Muxed read: address on data bus in T1
// - Muxed read T2: release bus, read strobes
// - Muxed write T2: data replaces address, write strobe
// - Muxed write: strobe drops at T4, buses held
// - Strobe mode runs eight states S0 to S7
// - S0 read drives read_not_write high
// - S1 presents full 24-bit address
// - S2 asserts both strobes; S3 unchanged
// - Muxed T1: low address byte on data lines
// - S4 waits for acknowledge, whole-state waits
// - S7 captures data, drops both strobes
// - One extra clock on bus mode change
module ebcs_sequencer
    import ebcs_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Per chip-select configuration
    input wire ebcs_cs_cfg_t [EBCS_NUM_CS-1:0] cs_cfg_i,
    // CPU-side request
    input wire logic req_valid_i,
    input wire ebcs_req_t req_i,
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [EBCS_DATA_W-1:0] rdata_o,
    // External bus
    input wire logic ready_i,
    input wire logic transfer_acknowledge_i,
    input wire logic [EBCS_DATA_W-1:0] data_i,
    output logic [EBCS_DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic [EBCS_ADDR_W-1:0] addr_o,
    output ebcs_ctl_t ctl_o,
    output logic [EBCS_CS_W-1:0] cs_sel_o
);

    typedef enum logic [3:0] {
        IDLE, SWITCH, T1, T2, T3, TW, T4,
        S0, S1, S2, S3, S4, S5, S6, S7
    } ebcs_state_t;

    ebcs_state_t state;
    ebcs_req_t cur;
    ebcs_cs_cfg_t cfg;
    ebcs_mode_t last_mode;
    logic last_valid;
    logic ready_low_seen;
    logic ack_seen;
    logic st_last;
    logic st_half;
    logic restart;
    logic latch_mode;
    logic muxed;

    assign latch_mode = (cfg.mode != EBCS_MODE_STROBE);
    assign muxed = (cfg.mode == EBCS_MODE_LATCH_MUX);
    assign restart = (state == IDLE) || (state == SWITCH);

    ebcs_state_timer u_timer (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .restart_i(restart),
        .len_i(cfg.state_len),
        .last_o(st_last),
        .half_o(st_half)
    );

    // Request capture; settings of the decoding chip select
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            cur <= '0;
            cfg <= '{mode: EBCS_MODE_LATCH, state_len: EBCS_LEN_RESET};
        end
        else if (clk_en_i && state == IDLE && req_valid_i)
        begin
            cur <= req_i;
            cfg <= cs_cfg_i[req_i.cs];
        end
    end

    // Ready sampled before T3; acknowledge sampled in S4
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            ready_low_seen <= 1'b0;
            ack_seen <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (state == T2 && !st_last && !ready_i)
                ready_low_seen <= 1'b1;
            else if (state == T1)
                ready_low_seen <= 1'b0;
            if ((state == S4 || state == S5) && st_last)
                ack_seen <= 1'b0;
            else if (state == S4 && !st_last && transfer_acknowledge_i)
                ack_seen <= 1'b1;
        end
    end

    // State sequencing
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state <= IDLE;
            last_mode <= EBCS_MODE_NATIVE;
            last_valid <= 1'b0;
        end
        else if (clk_en_i)
        begin
            unique case (state)
                IDLE:
                    if (req_valid_i)
                    begin
                        last_mode <= cs_cfg_i[req_i.cs].mode;
                        last_valid <= 1'b1;
                        // Mode change costs one clock
                        if (last_valid &&
                            cs_cfg_i[req_i.cs].mode != last_mode &&
                            cs_cfg_i[req_i.cs].mode != EBCS_MODE_NATIVE)
                            state <= SWITCH;
                        else if (cs_cfg_i[req_i.cs].mode == EBCS_MODE_STROBE)
                            state <= S0;
                        else
                            state <= T1;
                    end
                SWITCH:
                    state <= latch_mode ? T1 : S0;
                T1: if (st_last) state <= T2;
                T2: if (st_last) state <= T3;
                T3:
                    if (st_last)
                        state <= (ready_low_seen && !ready_i) ? TW : T4;
                TW:
                    if (st_last && ready_i)
                        state <= T4;
                T4: if (st_last) state <= IDLE;
                S0: if (st_last) state <= S1;
                S1: if (st_last) state <= S2;
                S2: if (st_last) state <= S3;
                S3: if (st_last) state <= S4;
                S4:
                    if (st_last)
                        // Late acknowledge on the last clock is too late
                        state <= ack_seen ? S5 : S4;
                S5: if (st_last) state <= S6;
                S6: if (st_last) state <= S7;
                S7: if (st_last) state <= IDLE;
            endcase
        end
    end

    // Bus pin drive; registered outputs
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            ctl_o <= EBCS_CTL_IDLE;
            addr_o <= '0;
            data_o <= '0;
            data_oe_o <= 1'b0;
            cs_sel_o <= '0;
        end
        else if (clk_en_i)
        begin
            // Entering T1
            if ((state == IDLE && req_valid_i &&
                 !(last_valid && cs_cfg_i[req_i.cs].mode != last_mode &&
                   cs_cfg_i[req_i.cs].mode != EBCS_MODE_NATIVE) &&
                 cs_cfg_i[req_i.cs].mode != EBCS_MODE_STROBE) ||
                (state == SWITCH && latch_mode))
            begin
                ebcs_req_t r;
                r = (state == IDLE) ? req_i : cur;
                addr_o <= r.addr;
                cs_sel_o <= r.cs;
                ctl_o.chip_select <= 1'b1;
                ctl_o.address_latch_strobe <= 1'b1;
                if ((state == IDLE ? cs_cfg_i[req_i.cs].mode : cfg.mode)
                    == EBCS_MODE_LATCH_MUX)
                begin
                    data_o <= r.addr[EBCS_DATA_W-1:0];
                    data_oe_o <= 1'b1;
                end
                else
                begin
                    data_o <= r.wdata;
                    data_oe_o <= r.write;
                end
            end
            else if (state == T1 && st_half)
                ctl_o.address_latch_strobe <= 1'b0;
            else if (state == T1 && st_last)
            begin
                ctl_o.read_strobe <= !cur.write;
                ctl_o.write_strobe <= cur.write;
                ctl_o.memory_request <= !cur.io;
                ctl_o.io_request <= cur.io;
                if (muxed)
                begin
                    data_o <= cur.wdata;
                    data_oe_o <= cur.write;
                end
            end
            // Last clock of T3 or a wait, going to T4, drops the read and write strobes
            else if ((state == T3 || state == TW) &&
                     st_last && (state == T3 ?
                     !(ready_low_seen && !ready_i) : ready_i))
            begin
                ctl_o.read_strobe <= 1'b0;
                ctl_o.write_strobe <= 1'b0;
            end
            else if (state == T4 && st_last)
            begin
                ctl_o <= EBCS_CTL_IDLE;
                data_oe_o <= 1'b0;
            end
            else if (state == SWITCH || (state == IDLE && req_valid_i))
            begin
                if (!latch_mode && state == SWITCH ||
                    state == IDLE &&
                    cs_cfg_i[req_i.cs].mode == EBCS_MODE_STROBE)
                    ctl_o.read_not_write <= 1'b1;
            end
            else if (state == S0 && st_last)
            begin
                addr_o <= cur.addr;
                cs_sel_o <= cur.cs;
                ctl_o.chip_select <= 1'b1;
            end
            else if (state == S1 && st_last)
            begin
                ctl_o.address_strobe <= 1'b1;
                ctl_o.data_strobe <= 1'b1;
            end
            else if (state == S6 && st_last)
            begin
                ctl_o.address_strobe <= 1'b0;
                ctl_o.data_strobe <= 1'b0;
            end
            else if (state == S7 && st_last)
                ctl_o <= EBCS_CTL_IDLE;
        end
    end

    // Read data capture at the start of T4 or S7
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            rdata_o <= '0;
            rdata_valid_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            rdata_valid_o <= 1'b0;
            if (st_last && !cur.write &&
                ((state == S6) || (state == T3 &&
                 !(ready_low_seen && !ready_i)) ||
                 (state == TW && ready_i)))
            begin
                rdata_o <= data_i;
                rdata_valid_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            req_ready_o <= 1'b0;
        else if (clk_en_i)
            req_ready_o <= (state == IDLE) && !req_valid_i;
    end

    // Assertions
    property p_t3_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        (clk_en_i && state == T3 && !st_last) |=> $stable(ctl_o);
    endproperty
    a_t3_hold: assert property (p_t3_hold)
        else $error("bus pins changed inside T3");

    property p_ale_pulse;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(ctl_o.address_latch_strobe) |-> state == T1;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse)
        else $error("latch strobe rose outside T1");

    property p_wr_t2;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(ctl_o.write_strobe) |->
            state == T2 && (ctl_o.memory_request ^ ctl_o.io_request);
    endproperty
    a_wr_t2: assert property (p_wr_t2)
        else $error("write strobe without T2 and one request");

    property p_wr_drop;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(ctl_o.write_strobe) |-> state == T4 && ctl_o.chip_select;
    endproperty
    a_wr_drop: assert property (p_wr_drop)
        else $error("write strobe fell outside T4");

    property p_rd_mux;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(ctl_o.read_strobe) && muxed |-> !data_oe_o;
    endproperty
    a_rd_mux: assert property (p_rd_mux)
        else $error("muxed read kept address on data bus");

    property p_strobes;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(ctl_o.address_strobe) |->
            ctl_o.data_strobe && state == S2 && ctl_o.read_not_write;
    endproperty
    a_strobes: assert property (p_strobes)
        else $error("strobes not raised together at S2");

    property p_s7;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(ctl_o.data_strobe) |-> state == S7 && rdata_valid_o;
    endproperty
    a_s7: assert property (p_s7)
        else $error("S7 capture or strobe drop missing");

    property p_switch;
        @(posedge core_clk_i) disable iff (reset_i)
        state == SWITCH && clk_en_i |=> state == T1 || state == S0;
    endproperty
    a_switch: assert property (p_switch)
        else $error("mode switch gap not one clock");

endmodule

`default_nettype wire

// ---- pkg/ebcs_pkg.sv ----
// Package: modes, states, timing constants and carriers for the sequencer
package ebcs_pkg;

    localparam int EBCS_ADDR_W = 24;
    localparam int EBCS_DATA_W = 8;
    localparam int EBCS_NUM_CS = 4;
    localparam int EBCS_CS_W = 2;

    // Four-state-mode state length bounds, in system clocks
    localparam logic [3:0] EBCS_LEN_MIN = 4'h2;
    localparam logic [3:0] EBCS_LEN_MAX = 4'hF;
    localparam logic [3:0] EBCS_LEN_RESET = 4'h2;
    // Four-state mode has four states per transfer
    localparam int EBCS_T_STATES = 4;
    // Strobe mode has eight states per transfer
    localparam int EBCS_S_STATES = 8;
    // Extra cycle when the bus mode changes between accesses
    localparam logic [3:0] EBCS_SWITCH_CYCLES = 4'h1;

    typedef enum logic [1:0] {
        EBCS_MODE_NATIVE,
        EBCS_MODE_LATCH,
        EBCS_MODE_LATCH_MUX,
        EBCS_MODE_STROBE
    } ebcs_mode_t;

    // Per chip-select configuration
    typedef struct packed {
        ebcs_mode_t mode;
        logic [3:0] state_len;
    } ebcs_cs_cfg_t;

    // Access request from the CPU side
    typedef struct packed {
        logic [EBCS_ADDR_W-1:0] addr;
        logic [EBCS_DATA_W-1:0] wdata;
        logic write;
        logic io;
        logic [EBCS_CS_W-1:0] cs;
    } ebcs_req_t;

    // Bus control pins, all active high
    typedef struct packed {
        logic chip_select;
        logic address_latch_strobe;
        logic read_strobe;
        logic write_strobe;
        logic memory_request;
        logic io_request;
        logic read_not_write;
        logic address_strobe;
        logic data_strobe;
    } ebcs_ctl_t;

    localparam ebcs_ctl_t EBCS_CTL_IDLE = '{default: 1'b0};

endpackage

// ---- core/ebcs_state_timer.sv ----
// State-length timer: pulses on the last clock of each bus state
`timescale 1ns/1ps
`default_nettype none

module ebcs_state_timer
    import ebcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Control
    input wire logic restart_i,
    input wire logic [3:0] len_i,
    // Status
    output logic last_o,
    output logic half_o
);

    logic [3:0] count;
    logic [3:0] len_eff;

    // Clamp to the legal range so a bad setting cannot hang a cycle
    always_comb
    begin
        if (len_i < EBCS_LEN_MIN)
            len_eff = EBCS_LEN_MIN;
        else
            len_eff = len_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            count <= 4'h0;
        else if (clk_en_i)
        begin
            if (restart_i || last_o)
                count <= 4'h0;
            else
                count <= count + 4'h1;
        end
    end

    assign last_o = (count == len_eff - 4'h1);
    assign half_o = (count == ((len_eff >> 1) - 4'h1));

endmodule

`default_nettype wire

// ---- verif/ebcs_periph_model.sv ----
// Peripheral model: answers ready, acknowledge and read data
`timescale 1ns/1ps
`default_nettype none

module ebcs_periph_model
    import ebcs_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Bus pins from the sequencer
    input wire ebcs_ctl_t ctl_i,
    // Behaviour chosen by the bench
    input wire logic [7:0] low_cycles_i,
    input wire logic [7:0] ack_dly_i,
    input wire logic [7:0] rval_i,
    // Answers
    output logic ready_o,
    output logic transfer_acknowledge_o,
    output logic [7:0] data_o
);
    logic [7:0] cs_cnt = 8'h00;
    logic [7:0] as_cnt = 8'h00;
    logic [7:0] last = 8'h00;
    logic rd_on;

    assign rd_on = ctl_i.read_strobe | ctl_i.data_strobe;
    // Low from select onward until the slow answer is due
    assign ready_o = !(ctl_i.chip_select && cs_cnt < low_cycles_i);
    assign transfer_acknowledge_o = ctl_i.address_strobe && as_cnt >= ack_dly_i;
    // Released bus shows inverted stale data, never a held copy
    assign data_o = rd_on ? rval_i : ~last;

    always @(posedge core_clk_i)
    begin
        cs_cnt <= ctl_i.chip_select ? cs_cnt + 8'h01 : 8'h00;
        as_cnt <= ctl_i.address_strobe ? as_cnt + 8'h01 : 8'h00;
        if (rd_on)
            last <= rval_i;
    end
endmodule
`default_nettype wire

// ---- verif/ext_bus_cycle_sequencer_tb_top.sv ----
// Testbench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none

module ext_bus_cycle_sequencer_tb_top
    import ebcs_pkg::*;
;
    logic core_clk_i;
    logic reset_i;
    ebcs_cs_cfg_t [EBCS_NUM_CS-1:0] cs_cfg;
    logic req_valid_i;
    ebcs_req_t req_i;
    logic req_ready_o;
    logic rdata_valid_o;
    logic [7:0] rdata_o;
    logic ready_i;
    logic ack_i;
    logic [7:0] data_i;
    logic [7:0] data_o;
    logic data_oe_o;
    logic [23:0] addr_o;
    ebcs_ctl_t ctl_o;
    logic [1:0] cs_sel_o;
    logic [7:0] low;
    logic [7:0] ack_dly;
    logic [7:0] rval;
    int failures = 0;
    int checked = 0;
    // Counts per ctl bit: 8 select, 7 latch, 6 rd, 5 wr, 1 as, 0 ds
    int st[9];
    int lat;
    int len;
    int x;
    int wt;
    ebcs_ctl_t c1;
    ebcs_ctl_t c2;
    ebcs_ctl_t c3;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] rd;
    logic oe1;
    logic oe2;
    logic [23:0] a1;
    logic [23:0] a2;
    logic [23:0] alast;
    logic [1:0] sel1;
    ebcs_mode_t pm;
    logic pv;

    ebcs_sequencer uut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
        .cs_cfg_i(cs_cfg), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o),
        .rdata_o(rdata_o), .ready_i(ready_i),
        .transfer_acknowledge_i(ack_i), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .addr_o(addr_o), .ctl_o(ctl_o),
        .cs_sel_o(cs_sel_o)
    );

    ebcs_periph_model periph (
        .core_clk_i(core_clk_i), .ctl_i(ctl_o), .low_cycles_i(low),
        .ack_dly_i(ack_dly), .rval_i(rval), .ready_o(ready_i),
        .transfer_acknowledge_o(ack_i), .data_o(data_i)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timeout();
        failures++;
        final_report();
    endtask

    // One transfer; records per-state snapshots and strobe counts
    task automatic xfer(input logic [1:0] c, input logic w, input logic io,
        input logic [23:0] a, input logic [7:0] wd, input int wts);
        int k;
        ebcs_mode_t m;
        m = cs_cfg[c].mode;
        wt = wts;
        len = (cs_cfg[c].state_len < 4'h2) ? 2 : int'(cs_cfg[c].state_len);
        x = (pv && m != EBCS_MODE_NATIVE && m != pm) ? 1 : 0;
        if (m != EBCS_MODE_NATIVE)
        begin
            pm = m;
            pv = 1'b1;
        end
        low = (wt == 0 || m == EBCS_MODE_STROBE) ? 8'h00
            : 8'((2 + wt) * len + len / 2);
        // Ready only shows with no request pending, so wait first
        k = 0;
        while (req_ready_o !== 1'b1)
        begin
            k++;
            if (k > 50)
                timeout();
            @(posedge core_clk_i);
            #1;
        end
        req_i = '{addr: a, wdata: wd, write: w, io: io, cs: c};
        req_valid_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        req_valid_i = 1'b0;
        st = '{default: 0};
        lat = 0;
        for (k = 1; k < 300; k++)
        begin
            if (k > 1 && req_ready_o === 1'b1)
                break;
            for (int i = 0; i < 9; i++)
                st[i] += int'(ctl_o[i] === 1'b1);
            if (k == 1 + x)
            begin
                c1 = ctl_o;
                d1 = data_o;
                oe1 = data_oe_o;
                a1 = addr_o;
                sel1 = cs_sel_o;
            end
            if (k == 1 + x + len)
            begin
                c2 = ctl_o;
                d2 = data_o;
                oe2 = data_oe_o;
                a2 = addr_o;
            end
            if (k == 1 + x + 2 * len)
                c3 = ctl_o;
            if (rdata_valid_o === 1'b1)
            begin
                lat = k;
                rd = rdata_o;
            end
            if (ctl_o.chip_select === 1'b1)
                alast = addr_o;
            @(posedge core_clk_i);
            #1;
        end
        if (k >= 300)
            timeout();
    endtask

    task automatic chk_latch();
        logic mux;
        mux = (cs_cfg[req_i.cs].mode == EBCS_MODE_LATCH_MUX);
        check(st[8], (4 + wt) * len);
        if (len % 2 == 0)
            check(st[7], len / 2);
        check(c1.address_latch_strobe, 1'b1);
        check(c1.chip_select, 1'b1);
        check(sel1, req_i.cs);
        check(a1, req_i.addr);
        check(alast, req_i.addr);
        check(oe1, req_i.write | mux);
        if (mux)
            check(d1, req_i.addr[7:0]);
        else if (req_i.write)
            check(d1, req_i.wdata);
        check(c2.memory_request, !req_i.io);
        check(c2.io_request, req_i.io);
        check(oe2, req_i.write);
        if (req_i.write)
        begin
            check(d2, req_i.wdata);
            check(st[5], (2 + wt) * len);
        end
        else
        begin
            check(st[6], (2 + wt) * len);
            check(lat, (3 + wt) * len + 1 + x);
            check(rd, rval);
        end
    endtask

    task automatic t_sep_read();
        cs_cfg[0] = '{mode: EBCS_MODE_LATCH, state_len: 4'h2};
        rval = 8'h5A;
        xfer(2'h0, 1'b0, 1'b0, 24'h12A5C3, 8'h00, 0);
        chk_latch();
        rval = 8'hC3;
        xfer(2'h0, 1'b0, 1'b1, 24'h00FF01, 8'h00, 1);
        chk_latch();
        $display("done separate read");
    endtask

    task automatic t_sep_write();
        cs_cfg[1] = '{mode: EBCS_MODE_LATCH, state_len: 4'hF};
        xfer(2'h1, 1'b1, 1'b0, 24'hABCDEF, 8'h96, 0);
        chk_latch();
        cs_cfg[1].state_len = 4'h4;
        xfer(2'h1, 1'b1, 1'b1, 24'h800001, 8'h3C, 2);
        chk_latch();
        $display("done separate write");
    endtask

    // Mode change from the latch chip select costs one clock
    task automatic t_mux();
        cs_cfg[2] = '{mode: EBCS_MODE_LATCH_MUX, state_len: 4'h2};
        rval = 8'hE7;
        xfer(2'h2, 1'b0, 1'b0, 24'h3344A6, 8'h00, 1);
        chk_latch();
        xfer(2'h2, 1'b1, 1'b0, 24'h55AA18, 8'h81, 0);
        chk_latch();
        $display("done multiplexed");
    endtask

    task automatic t_clamp();
        cs_cfg[1] = '{mode: EBCS_MODE_LATCH, state_len: 4'h1};
        rval = 8'h24;
        xfer(2'h1, 1'b0, 1'b0, 24'h0F0F0F, 8'h00, 0);
        chk_latch();
        $display("done short length");
    endtask

    task automatic chk_strobe();
        check(c1.read_not_write, 1'b1);
        check(a2, req_i.addr);
        check(c3.address_strobe & c3.data_strobe, 1'b1);
        check(st[1], (5 + wt) * len);
        check(st[0], (5 + wt) * len);
        check(lat, (7 + wt) * len + 1 + x);
        check(rd, rval);
    endtask

    task automatic t_strobe();
        cs_cfg[3] = '{mode: EBCS_MODE_STROBE, state_len: 4'h2};
        rval = 8'h69;
        ack_dly = 8'h00;
        xfer(2'h3, 1'b0, 1'b0, 24'hFEDCBA, 8'h00, 0);
        chk_strobe();
        // Late acknowledge lands mid-way through one wait state
        cs_cfg[3].state_len = 4'h4;
        rval = 8'hB2;
        ack_dly = 8'h0D;
        xfer(2'h3, 1'b0, 1'b0, 24'h010203, 8'h00, 1);
        chk_strobe();
        $display("done strobe read");
    endtask

    initial
    begin
        reset_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        cs_cfg = '0;
        rval = 8'h00;
        ack_dly = 8'h00;
        low = 8'h00;
        pv = 1'b0;
        pm = EBCS_MODE_NATIVE;
        repeat (4) @(posedge core_clk_i);
        #1;
        reset_i = 1'b0;
        check(ctl_o, EBCS_CTL_IDLE);
        t_sep_read();
        t_sep_write();
        t_mux();
        t_clamp();
        t_strobe();
        final_report();
    end
endmodule
`default_nettype wire
